/* core/tio_cfg.svh */
/*
  Offsets, field positions, reset values and scale figures of the
  three-phase instantaneous overcurrent block.
  Assumes it is included once per file by its bare name.
*/
`ifndef TIO_CFG_SVH
`define TIO_CFG_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define TIO_ADDR_MODE       8'h00
`define TIO_ADDR_THRESH     8'h04
`define TIO_ADDR_STATE      8'h08
`define TIO_ADDR_IRQ_STATUS 8'h0c
`define TIO_ADDR_IRQ_MASK   8'h10
`define TIO_ADDR_PEAK_A     8'h14
`define TIO_ADDR_PEAK_B     8'h18
`define TIO_ADDR_PEAK_C     8'h1c

// ********************************************************************
// Fields, limits and reset values
// ********************************************************************
`define TIO_MODE_LSB        0
`define TIO_MODE_MSB        1
`define TIO_THRESH_MSB      11
`define TIO_THRESH_MIN      12'h014
`define TIO_THRESH_MAX      12'hbb8
`define TIO_THRESH_RESET    12'h0c8
`define TIO_PERCENT_SCALE   32'h00000064
`define TIO_IRQ_BITS        4
`define TIO_IRQ_RESET       4'h0

`endif

/* core/tio_pkg.sv */
/*
  Types of the overcurrent block; its peak selector uses none of them.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tio_pkg;

  typedef enum logic [1:0] {
    TIO_MODE_OFF,
    TIO_MODE_PEAK,
    TIO_MODE_FUNDAMENTAL
  } tio_mode_type;

  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } tio_trip_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } tio_ahb_req_type;

endpackage : tio_pkg

/* core/tio_peak_select.sv */
/*
  Peak selector for one phase: magnitude of each sample, maximum over a
  window of samples, output as the larger of last window and current one.
  Assumes samples are two's complement and arrive with a one-cycle strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tio_cfg.svh"

module tio_peak_select #(
  parameter int WIDTH  = 16,
  parameter int WINDOW = 20
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             sample_valid,
  input  wire logic [WIDTH-1:0] sample,
  output logic      [WIDTH-1:0] peak_value
);

  // ********************************************************************
  // Magnitude and window tracking
  // ********************************************************************
  wire logic [WIDTH-1:0] magnitude;
  wire logic             window_end;
  wire logic [WIDTH-1:0] run_max;
  logic      [WIDTH-1:0] run_ff;
  logic      [WIDTH-1:0] last_ff;
  logic      [15:0]      count_ff;

  assign magnitude  = sample[WIDTH-1] ? WIDTH'(~sample + 1'b1) : sample;
  assign run_max    = (magnitude > run_ff) ? magnitude : run_ff;
  assign window_end = (count_ff == 16'(WINDOW - 1));

  // Holding the previous window keeps the peak steady between crests
  // while still following a rising current at once.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      run_ff     <= '0;
      last_ff    <= '0;
      count_ff   <= 16'h0000;
      peak_value <= '0;
    end
    else if (sample_valid)
    begin
      run_ff     <= window_end ? '0 : run_max;
      last_ff    <= window_end ? run_max : last_ff;
      count_ff   <= window_end ? 16'h0000 : count_ff + 16'h0001;
      peak_value <= (run_max > last_ff) ? run_max : last_ff;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_PEAK_COVERS_SAMPLE: assert property (
    sample_valid |=> peak_value >= $past(magnitude))
    else $error("Peak value fell below the last sample magnitude.");

endmodule : tio_peak_select
`default_nettype wire

/* core/tio_phase_instant_overcurrent.sv */
/*
  Three-phase instantaneous overcurrent decision with an AHB-Lite
  register slave, sticky trip events and one level interrupt.
  Assumes samples, fundamental values and the two request inputs come
  from logic on the same clock, and that the bus is single-slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tio_cfg.svh"

// Notes on behaviour
// - Mode off, peak or fundamental; resets off.
// - Peak mode compares peaks, else fundamental values.
// - Threshold percent 20 to 3000, default 200.
// - Phase trips when above threshold, no delay.
// - Equal to threshold never trips.
// - Doubling input doubles threshold for all phases.
// - Disable input forces every trip low.
// - Separate peak detection per phase stream.
// - General trip derived from phase trips.
// - General trip high if any phase trips.
module tio_phase_instant_overcurrent #(
  parameter int          WIDTH       = 16,
  parameter int          PEAK_WINDOW = 20,
  parameter logic [15:0] RATED_VALUE = 16'h1000
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  input  wire logic             sample_valid,
  input  wire logic [WIDTH-1:0] phase_a_samples,
  input  wire logic [WIDTH-1:0] phase_b_samples,
  input  wire logic [WIDTH-1:0] phase_c_samples,
  input  wire logic [WIDTH-1:0] phase_a_fundamental_rms,
  input  wire logic [WIDTH-1:0] phase_b_fundamental_rms,
  input  wire logic [WIDTH-1:0] phase_c_fundamental_rms,
  input  wire logic             disable_request,
  input  wire logic             threshold_double_request,
  output logic                  phase_a_trip,
  output logic                  phase_b_trip,
  output logic                  phase_c_trip,
  output logic                  any_phase_trip,
  output logic                  irq
);

  // ********************************************************************
  // Threshold arithmetic
  // ********************************************************************
  // Current times one hundred against rated value times percent keeps
  // the whole comparison in integers, with no divider.
  function automatic logic [31:0] level_of(input logic [11:0] pct,
                                            input logic        dbl);
    logic [31:0] rhs;
    rhs = {16'h0000, RATED_VALUE} * {20'h00000, pct};
    return dbl ? {rhs[30:0], 1'b0} : rhs;
  endfunction : level_of

  function automatic logic [31:0] scaled(input logic [WIDTH-1:0] val);
    return 32'(val) * `TIO_PERCENT_SCALE;
  endfunction : scaled

  // ********************************************************************
  // Register state
  // ********************************************************************
  tio_pkg::tio_mode_type         mode_ff;
  logic [`TIO_THRESH_MSB:0]      thresh_ff;
  logic [`TIO_IRQ_BITS-1:0]      irq_status_ff;
  logic [`TIO_IRQ_BITS-1:0]      irq_mask_ff;
  tio_pkg::tio_ahb_req_type      req_ff;
  tio_pkg::tio_ahb_req_type      nxt_req;
  tio_pkg::tio_trip_type         trip_ff;
  tio_pkg::tio_trip_type         nxt_trip;
  logic                          gen_ff;
  logic [31:0]                   nxt_rdata;

  // ********************************************************************
  // Peak selection, one per phase
  // ********************************************************************
  wire logic [WIDTH-1:0] phase_a_peak_value;
  wire logic [WIDTH-1:0] phase_b_peak_value;
  wire logic [WIDTH-1:0] phase_c_peak_value;

  tio_peak_select #(.WIDTH(WIDTH), .WINDOW(PEAK_WINDOW)) u_peak_a (
    .clock        (clock),
    .reset        (reset),
    .sample_valid (sample_valid),
    .sample       (phase_a_samples),
    .peak_value   (phase_a_peak_value)
  );

  tio_peak_select #(.WIDTH(WIDTH), .WINDOW(PEAK_WINDOW)) u_peak_b (
    .clock        (clock),
    .reset        (reset),
    .sample_valid (sample_valid),
    .sample       (phase_b_samples),
    .peak_value   (phase_b_peak_value)
  );

  tio_peak_select #(.WIDTH(WIDTH), .WINDOW(PEAK_WINDOW)) u_peak_c (
    .clock        (clock),
    .reset        (reset),
    .sample_valid (sample_valid),
    .sample       (phase_c_samples),
    .peak_value   (phase_c_peak_value)
  );

  // ********************************************************************
  // Instantaneous decision
  // ********************************************************************
  wire logic             use_peak;
  wire logic             active;
  wire logic [WIDTH-1:0] eval_a;
  wire logic [WIDTH-1:0] eval_b;
  wire logic [WIDTH-1:0] eval_c;
  wire logic [31:0]      level;

  assign use_peak = (mode_ff == tio_pkg::TIO_MODE_PEAK);
  assign active   = (mode_ff != tio_pkg::TIO_MODE_OFF) && !disable_request;
  assign eval_a   = use_peak ? phase_a_peak_value : phase_a_fundamental_rms;
  assign eval_b   = use_peak ? phase_b_peak_value : phase_b_fundamental_rms;
  assign eval_c   = use_peak ? phase_c_peak_value : phase_c_fundamental_rms;
  assign level    = level_of(thresh_ff, threshold_double_request);

  // Strictly greater: a current sitting on the setting stays quiet.
  assign nxt_trip.a = active && (scaled(eval_a) > level);
  assign nxt_trip.b = active && (scaled(eval_b) > level);
  assign nxt_trip.c = active && (scaled(eval_c) > level);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      trip_ff <= '0;
      gen_ff  <= 1'b0;
    end
    else
    begin
      trip_ff <= nxt_trip;
      gen_ff  <= |nxt_trip;
    end
  end

  assign phase_a_trip   = trip_ff.a;
  assign phase_b_trip   = trip_ff.b;
  assign phase_c_trip   = trip_ff.c;
  assign any_phase_trip = gen_ff;

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  wire logic [3:0]  trip_vec;
  wire logic [3:0]  trip_rise;
  logic      [3:0]  trip_prev_ff;
  wire logic        wr_en;
  wire logic        wr_mode;
  wire logic        wr_thresh;
  wire logic        wr_status;
  wire logic        wr_mask;
  wire logic [11:0] wr_pct;
  wire logic        pct_ok;
  wire logic        mode_ok;

  assign trip_vec  = {gen_ff, trip_ff.c, trip_ff.b, trip_ff.a};
  assign trip_rise = trip_vec & ~trip_prev_ff;

  assign nxt_req.valid = hsel && htrans[1] && hready;
  assign nxt_req.write = hwrite;
  assign nxt_req.addr  = {haddr[7:2], 2'b00};

  assign wr_en     = req_ff.valid && req_ff.write;
  assign wr_mode   = wr_en && (req_ff.addr == `TIO_ADDR_MODE);
  assign wr_thresh = wr_en && (req_ff.addr == `TIO_ADDR_THRESH);
  assign wr_status = wr_en && (req_ff.addr == `TIO_ADDR_IRQ_STATUS);
  assign wr_mask   = wr_en && (req_ff.addr == `TIO_ADDR_IRQ_MASK);
  assign wr_pct    = hwdata[`TIO_THRESH_MSB:0];
  // Out-of-range settings are dropped so the live threshold stays legal.
  assign pct_ok    = (hwdata[31:12] == 20'h00000) && (wr_pct >= `TIO_THRESH_MIN)
                     && (wr_pct <= `TIO_THRESH_MAX);
  assign mode_ok   = (hwdata[31:2] == 30'h00000000) && (hwdata[1:0] != 2'b11);

  always_comb
  begin
    nxt_rdata = 32'h00000000;
    case (nxt_req.addr)
      `TIO_ADDR_MODE:       nxt_rdata = {30'h00000000, mode_ff};
      `TIO_ADDR_THRESH:     nxt_rdata = {20'h00000, thresh_ff};
      `TIO_ADDR_STATE:      nxt_rdata = {26'h0000000, disable_request,
                                         threshold_double_request, trip_vec};
      `TIO_ADDR_IRQ_STATUS: nxt_rdata = {28'h0000000, irq_status_ff};
      `TIO_ADDR_IRQ_MASK:   nxt_rdata = {28'h0000000, irq_mask_ff};
      `TIO_ADDR_PEAK_A:     nxt_rdata = 32'(phase_a_peak_value);
      `TIO_ADDR_PEAK_B:     nxt_rdata = 32'(phase_b_peak_value);
      `TIO_ADDR_PEAK_C:     nxt_rdata = 32'(phase_c_peak_value);
      default:              nxt_rdata = 32'h00000000;
    endcase
  end

  // ********************************************************************
  // Register updates
  // ********************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      req_ff    <= '0;
      hrdata    <= 32'h00000000;
      mode_ff   <= tio_pkg::TIO_MODE_OFF;
      thresh_ff <= `TIO_THRESH_RESET;
    end
    else
    begin
      req_ff <= nxt_req;
      hrdata <= (nxt_req.valid && !hwrite) ? nxt_rdata : 32'h00000000;
      if (wr_mode && mode_ok)
        mode_ff <= tio_pkg::tio_mode_type'(hwdata[`TIO_MODE_MSB:`TIO_MODE_LSB]);
      if (wr_thresh && pct_ok)
        thresh_ff <= wr_pct;
    end
  end

  // A trip edge in the same cycle as its clear keeps the bit set.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      trip_prev_ff  <= 4'h0;
      irq_status_ff <= `TIO_IRQ_RESET;
      irq_mask_ff   <= `TIO_IRQ_RESET;
    end
    else
    begin
      trip_prev_ff  <= trip_vec;
      irq_status_ff <= (irq_status_ff & ~(wr_status ? hwdata[3:0] : 4'h0)) | trip_rise;
      if (wr_mask)
        irq_mask_ff <= hwdata[3:0];
    end
  end

  assign irq       = |(irq_status_ff & irq_mask_ff);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_peak_hit;
    use_peak && !disable_request && sample_valid
      && (scaled(phase_a_samples[WIDTH-1] ? WIDTH'(~phase_a_samples + 1'b1)
                                          : phase_a_samples) > level);
  endsequence

  sequence s_peak_held;
    use_peak && !disable_request && $stable(level);
  endsequence

  AST_MODE_RESET_OFF: assert property (disable iff (1'b0)
    reset |=> mode_ff == tio_pkg::TIO_MODE_OFF && thresh_ff == `TIO_THRESH_RESET)
    else $error("Mode or threshold wrong after reset.");

  AST_THRESH_RANGE: assert property (
    thresh_ff >= `TIO_THRESH_MIN && thresh_ff <= `TIO_THRESH_MAX)
    else $error("Threshold left its legal range.");

  AST_PEAK_TRIPS_TWO: assert property (
    s_peak_hit ##1 s_peak_held |=> phase_a_trip)
    else $error("Peak above threshold did not trip phase a in two cycles.");

  AST_FUND_TRIP: assert property (
    mode_ff == tio_pkg::TIO_MODE_FUNDAMENTAL && !disable_request
      && scaled(phase_b_fundamental_rms) > level |=> phase_b_trip)
    else $error("Fundamental above threshold did not trip phase b.");

  AST_EQUAL_QUIET: assert property (
    scaled(eval_c) == level |=> !phase_c_trip)
    else $error("Current equal to threshold tripped phase c.");

  AST_DOUBLE_QUIET: assert property (
    threshold_double_request && scaled(eval_a) <= 32'(RATED_VALUE)
      * 32'(thresh_ff) * 32'h00000002 |=> !phase_a_trip)
    else $error("Doubled threshold not applied to phase a.");

  AST_DISABLE_QUIET: assert property (
    disable_request [*2] |-> !any_phase_trip && !phase_a_trip)
    else $error("Trip present while disable held.");

  AST_OFF_QUIET: assert property (
    $past(mode_ff) == tio_pkg::TIO_MODE_OFF |-> trip_vec == 4'h0)
    else $error("Trip present while mode off.");

  AST_GENERAL_OR: assert property (
    any_phase_trip == (phase_a_trip || phase_b_trip || phase_c_trip))
    else $error("General trip disagrees with phase trips.");

  AST_TRIP_EVENT: assert property (
    $rose(any_phase_trip) |=> irq_status_ff[3])
    else $error("General trip edge not recorded.");

endmodule : tio_phase_instant_overcurrent
`default_nettype wire

/* test/tio_upstream_model.sv */
/*
  Model of the upstream sampling and fundamental stage of the overcurrent block.
  Assumes the bench drives its command inputs just after rising clock edges.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Upstream stage model
// ****************************************************************
module tio_upstream_model (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             cmd_strobe,
  input  wire logic [2:0][15:0] cmd_samples,
  input  wire logic [2:0][15:0] cmd_fundamental,
  output logic                  sample_valid,
  output logic      [2:0][15:0] samples,
  output logic      [2:0][15:0] fundamental
);
  // Outside a strobe the sample lines toggle every cycle, so a peak stage that
  // reads them without the strobe picks up garbage rather than a stale value.
  always @(posedge clock)
  begin
    if (reset)
    begin
      sample_valid <= 1'h0;
      samples      <= '0;
      fundamental  <= '0;
    end
    else
    begin
      sample_valid <= cmd_strobe;
      samples      <= cmd_strobe ? cmd_samples : ~samples;
      fundamental  <= cmd_fundamental;
    end
  end
endmodule : tio_upstream_model

`default_nettype wire

/* test/tb.sv */
/*
  Self-checking bench of the three-phase instantaneous overcurrent block.
  Assumes the block is the only slave on its bus and answers with OKAY.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tio_cfg.svh"

module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int RATED = 32'h1000;
  logic             clock = 1'h0;
  logic             reset = 1'h1;
  logic             hsel = 1'h0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'h0;
  logic [31:0]      hwdata = 32'h0;
  logic             hreadyout;
  logic             hresp;
  logic [31:0]      hrdata;
  logic             disable_request = 1'h0;
  logic             threshold_double_request = 1'h0;
  logic             cmd_strobe = 1'h0;
  logic [2:0][15:0] cmd_samples = '0;
  logic [2:0][15:0] cmd_fund = '0;
  logic             sv;
  logic [2:0][15:0] smp;
  logic [2:0][15:0] fund;
  logic             trip_a;
  logic             trip_b;
  logic             trip_c;
  logic             trip_any;
  logic             irq;
  int               n_fail = 0;
  int               check_count = 0;
  int               thr[2] = '{32'hc8, 32'h14};

  always #25 clock = ~clock;

  tio_upstream_model up (
    .clock(clock), .reset(reset), .cmd_strobe(cmd_strobe), .cmd_samples(cmd_samples),
    .cmd_fundamental(cmd_fund), .sample_valid(sv), .samples(smp), .fundamental(fund)
  );

  tio_phase_instant_overcurrent #(
    .WIDTH(16), .PEAK_WINDOW(4), .RATED_VALUE(16'h1000)
  ) dut (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_valid(sv),
    .phase_a_samples(smp[0]), .phase_b_samples(smp[1]), .phase_c_samples(smp[2]),
    .phase_a_fundamental_rms(fund[0]), .phase_b_fundamental_rms(fund[1]),
    .phase_c_fundamental_rms(fund[2]), .disable_request(disable_request),
    .threshold_double_request(threshold_double_request), .phase_a_trip(trip_a),
    .phase_b_trip(trip_b), .phase_c_trip(trip_c), .any_phase_trip(trip_any), .irq(irq)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict;
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      n_fail++;
    end
  endtask : check_word

  task automatic check_trip(input logic [3:0] e);
    check_count++;
    if ({trip_any, trip_c, trip_b, trip_a} !== e)
    begin
      $display("wrong value trips expected %h seen %h", e, {trip_any, trip_c, trip_b, trip_a});
      n_fail++;
    end
  endtask : check_trip

  // The master waits on hready after the address phase and after the data phase; only the watchdog ends a hang.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'h1)
      @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'h1)
      @(posedge clock);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'h1, a, d, rd);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string name);
    logic [31:0] rd;
    bus(1'h0, a, 32'h0, rd);
    check_word(name, e, rd);
    check_word("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic irq_chk(input logic e);
    @(posedge clock);
    check_word("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_chk

  task automatic apply(input logic [47:0] f);
    @(posedge clock);
    cmd_fund <= f;
    repeat (3) @(posedge clock);
  endtask : apply

  task automatic pulse(input logic [47:0] s, input int n);
    repeat (n)
    begin
      @(posedge clock);
      cmd_strobe  <= 1'h1;
      cmd_samples <= s;
    end
    @(posedge clock);
    cmd_strobe <= 1'h0;
    repeat (3) @(posedge clock);
  endtask : pulse

  function automatic logic exp_trip(input int v, input int t, input int d);
    return v * 32'h64 > RATED * t * (d + 1);
  endfunction : exp_trip

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    int   v;
    logic e;
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    rchk(`TIO_ADDR_MODE, 32'h0, "mode");
    rchk(`TIO_ADDR_THRESH, 32'hc8, "thresh");
    rchk(`TIO_ADDR_IRQ_MASK, 32'h0, "mask");
    wr(8'h20, 32'hffffffff);
    rchk(8'h20, 32'h0, "unmapped");
    wr(`TIO_ADDR_MODE, 32'h3);
    rchk(`TIO_ADDR_MODE, 32'h0, "mode");
    wr(`TIO_ADDR_THRESH, 32'h13);
    rchk(`TIO_ADDR_THRESH, 32'hc8, "thresh");
    wr(`TIO_ADDR_THRESH, 32'hbb8);
    rchk(`TIO_ADDR_THRESH, 32'hbb8, "thresh");
    wr(`TIO_ADDR_THRESH, 32'hbb9);
    rchk(`TIO_ADDR_THRESH, 32'hbb8, "thresh");
    threshold_double_request <= 1'h1;
    apply(48'hffffffffffff);
    check_trip(4'h0);
    wr(`TIO_ADDR_MODE, 32'h2);
    for (int ti = 0; ti < 2; ti++)
    begin
      wr(`TIO_ADDR_THRESH, thr[ti]);
      for (int d = 0; d < 2; d++)
      begin
        threshold_double_request <= d[0];
        for (int k = 0; k < 2; k++)
        begin
          v = RATED * thr[ti] * (d + 1) / 32'h64 + k;
          e = exp_trip(v, thr[ti], d);
          for (int p = 0; p < 3; p++)
          begin
            apply(48'(v) << (16 * p));
            check_trip({e, 3'(e) << p});
          end
        end
      end
    end
    wr(`TIO_ADDR_THRESH, 32'hc8);
    threshold_double_request <= 1'h0;
    disable_request <= 1'h1;
    apply(48'hffffffffffff);
    check_trip(4'h0);
    rchk(`TIO_ADDR_STATE, 32'h20, "state");
    disable_request <= 1'h0;
    apply(48'hffffffffffff);
    check_trip(4'hf);
    rchk(`TIO_ADDR_STATE, 32'hf, "state");
    irq_chk(1'h0);
    wr(`TIO_ADDR_IRQ_MASK, 32'h8);
    irq_chk(1'h1);
    apply(48'h0);
    wr(`TIO_ADDR_IRQ_STATUS, 32'hf);
    rchk(`TIO_ADDR_IRQ_STATUS, 32'h0, "status");
    irq_chk(1'h0);
    apply(48'hffff);
    rchk(`TIO_ADDR_IRQ_STATUS, 32'h9, "status");
    irq_chk(1'h1);
    wr(`TIO_ADDR_IRQ_MASK, 32'h2);
    irq_chk(1'h0);
    // Peak mode ignores the large fundamentals; only sample peaks count.
    wr(`TIO_ADDR_MODE, 32'h1);
    apply(48'hffffffffffff);
    pulse(48'h0, 9);
    check_trip(4'h0);
    pulse({16'h2000, 16'hdfff, 16'h0000}, 1);
    check_trip(4'ha);
    rchk(`TIO_ADDR_PEAK_A, 32'h0, "peak a");
    rchk(`TIO_ADDR_PEAK_B, 32'h2001, "peak b");
    rchk(`TIO_ADDR_PEAK_C, 32'h2000, "peak c");
    pulse(48'h0, 9);
    check_trip(4'h0);
    pulse({32'h0, 16'h2100}, 1);
    check_trip(4'h9);
    rchk(`TIO_ADDR_PEAK_A, 32'h2100, "peak a");
    print_verdict();
  end

  initial
  begin
    repeat (32'h4e20) @(posedge clock);
    n_fail++;
    print_verdict();
  end
endmodule : tb

`default_nettype wire
